// [core/dst_map.svh]
// Timing constants for the rank state-exit guard
`ifndef DST_MAP_SVH
`define DST_MAP_SVH

`define DST_CK_PS          100000
`define DST_NS2CK(ns)      ((((ns) * 1000) + `DST_CK_PS - 1) / `DST_CK_PS)
`define DST_MAX(a, b)      (((a) > (b)) ? (a) : (b))
`define DST_ZQINIT_NCK     1024
`define DST_ZQOPER_NCK     512
`define DST_ZQCS_NCK       128
`define DST_XPR_NCK        5
`define DST_XPR_ADD_NS     10
`define DST_XS_ADD_NS      10
`define DST_CKV_NCK        5
`define DST_CKV_NS         10
`define DST_CKE_NCK        3
`define DST_CKE_NS         5
`define DST_CKESR_ADD_NCK  1
`define DST_CPDED_NCK      4
`define DST_XP_NCK         4
`define DST_XP_NS          6
`define DST_TMR_W          12
`define DST_TMR_N          7
`define DST_T_BUSY         0
`define DST_T_NODLL        1
`define DST_T_FAST         2
`define DST_T_DLL          3
`define DST_T_CKE          4
`define DST_T_AFTER        5
`define DST_T_BEFORE       6

`endif

// [core/dst_pkg.sv]
// Types shared by the rank state-exit guard
package dst_pkg;

    typedef enum logic [3:0] {
        DST_CMD_NOP      = 4'h0,
        DST_CMD_ZQCL     = 4'h1,
        DST_CMD_ZQCS     = 4'h2,
        DST_CMD_MRS_FAST = 4'h3,
        DST_CMD_NODLL    = 4'h4,
        DST_CMD_DLL      = 4'h5,
        DST_CMD_SRE      = 4'h6,
        DST_CMD_SRX      = 4'h7,
        DST_CMD_PDE      = 4'h8,
        DST_CMD_PDX      = 4'h9,
        DST_CMD_MPSME    = 4'ha,
        DST_CMD_MPSMX    = 4'hb,
        DST_CMD_RSTX     = 4'hc
    } dst_cmd_t;

    typedef enum logic [2:0] {
        DST_ST_RESET = 3'h0,
        DST_ST_IDLE  = 3'h1,
        DST_ST_SR    = 3'h3,
        DST_ST_MPSM  = 3'h2,
        DST_ST_PD    = 3'h6
    } dst_rank_t;

    typedef struct packed {
        dst_rank_t pstate;
        logic      ck_en;
        logic      cke;
        logic      booted;
        logic      first_zq;
        dst_cmd_t  cmd_out;
        logic      cmd_stb;
    } dst_state_t;

endpackage

// [core/dst_timer.sv]
// Countdown interval timer that never shortens a pending interval
`timescale 1ns/1ps
module dst_timer #(
    parameter int W = 12
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done,
    output logic [W-1:0]      remain
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } dst_tmr_t;

    dst_tmr_t st_reg;
    dst_tmr_t st_next;

    if (W < 2) begin : g_chk
        $error("dst_timer width too small");
    end

    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        // The longer of the running and the new interval wins
        if (load && (value > st_next.cnt)) begin
            st_next.cnt = value;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done   = (st_reg.cnt == '0);
    assign remain = st_reg.cnt;

endmodule

// [core/dst_guard.sv]
// Rank command gate enforcing calibration and state-exit intervals
// Summary of operation
// - After reset exit, first long calibration blocks all commands except NOP 1024 cycles.
// - Long calibration in normal operation blocks the rank for 512 cycles.
// - Short calibration blocks the rank for 128 cycles.
// - After CKE rises out of reset, wait max(5 cycles, tRFC+10ns).
// - After self refresh exit, non-DLL commands wait tRFC+10ns.
// - With self refresh abort, non-DLL commands wait tRFC4+10ns.
// - Calibration and fast mode writes may follow exit after tRFC4+10ns.
// - DLL commands after self refresh exit wait the DLL lock time.
// - CKE stays low tCKE+1 cycle in self refresh, plus PL with parity.
// - Clock stays valid max(5 cycles,10ns) after entry, plus PL with parity.
// - Clock valid max(5 cycles,10ns) before self refresh, power-down, reset exit.
// - Clock stays valid tMOD+tCPDED after power saving mode entry.
// - Clock valid before power saving exit as long as before self refresh exit.
// - Non-DLL commands after power saving exit wait the self refresh exit delay.
// - DLL commands after power saving exit wait that delay plus DLL lock.
// - Command path disable delay counts at least 4 cycles.
// - Minimum CKE pulse width is max(3 cycles, 5ns).
`timescale 1ns/1ps
`include "dst_map.svh"
module dst_guard #(
    parameter int RFC_NS   = 550,
    parameter int RFC4_NS  = 160,
    parameter int DLLK_NCK = 768,
    parameter int MOD_NCK  = 24,
    parameter int PL_NCK   = 4,
    parameter int W        = `DST_TMR_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              cmd_valid,
    input  wire dst_pkg::dst_cmd_t cmd_kind,
    output logic                   cmd_ready,
    input  wire logic              ck_stop_req,
    input  wire logic              par_en,
    input  wire logic              sr_abort,
    output logic                   ddr_ck_en,
    output logic                   ddr_cke,
    output dst_pkg::dst_cmd_t      ddr_cmd,
    output logic                   ddr_cmd_stb,
    output dst_pkg::dst_rank_t     rank_state,
    output logic [`DST_TMR_N-1:0]  tmr_running
);

    localparam int N = `DST_TMR_N;

    // Cycle counts, least times rounded up
    localparam int XPR_C =
        `DST_MAX(`DST_XPR_NCK, `DST_NS2CK(RFC_NS + `DST_XPR_ADD_NS));
    localparam int XS_C = `DST_NS2CK(RFC_NS + `DST_XS_ADD_NS);
    localparam int XS4_C = `DST_NS2CK(RFC4_NS + `DST_XS_ADD_NS);
    localparam int CKV_C =
        `DST_MAX(`DST_CKV_NCK, `DST_NS2CK(`DST_CKV_NS));
    localparam int CKE_C =
        `DST_MAX(`DST_CKE_NCK, `DST_NS2CK(`DST_CKE_NS));
    localparam int CKESR_C = CKE_C + `DST_CKESR_ADD_NCK;
    localparam int MPE_C = MOD_NCK + `DST_CPDED_NCK;
    localparam int XMPDLL_C = XS_C + DLLK_NCK;
    localparam int XP_C = `DST_MAX(`DST_XP_NCK, `DST_NS2CK(`DST_XP_NS));

    if (XMPDLL_C >= (1 << W) || `DST_ZQINIT_NCK >= (1 << W) ||
        CKE_C + PL_NCK + 1 >= (1 << W) || MPE_C >= (1 << W)) begin : g_chk
        $error("dst_guard timer width too small for the intervals");
    end

    if (RFC_NS < 1 || RFC4_NS < 1 || DLLK_NCK < 1 || MOD_NCK < 1 ||
        PL_NCK < 0) begin : g_par_chk
        $error("dst_guard timing parameters out of range");
    end

    logic                 rst_s1_reg;
    logic                 rst_s2_reg;
    logic                 rst_int_n;
    dst_pkg::dst_state_t  st_reg;
    dst_pkg::dst_state_t  st_next;
    logic [N-1:0]         ld;
    logic [N-1:0][W-1:0]  val;
    logic [N-1:0]         done;
    logic                 accept;
    logic                 asleep;
    logic [W-1:0]         pl_add;

    function automatic logic [W-1:0] cyc(input int n);
        return W'(n);
    endfunction

    // Readiness of a command class in the present rank state
    function automatic logic dst_ok(
        input dst_pkg::dst_cmd_t  k,
        input dst_pkg::dst_rank_t s,
        input logic [N-1:0]       d,
        input logic               fz,
        input logic               ck
    );
        logic idle_ok;
        logic r;
        idle_ok = ck && (s == dst_pkg::DST_ST_IDLE) && d[`DST_T_BUSY];
        r = 1'b0;
        case (k)
            dst_pkg::DST_CMD_NOP: begin
                r = ck;
            end
            dst_pkg::DST_CMD_ZQCL, dst_pkg::DST_CMD_ZQCS,
            dst_pkg::DST_CMD_MRS_FAST: begin
                r = idle_ok && d[`DST_T_FAST] &&
                    (!fz || k == dst_pkg::DST_CMD_ZQCL);
            end
            dst_pkg::DST_CMD_NODLL, dst_pkg::DST_CMD_SRE,
            dst_pkg::DST_CMD_PDE, dst_pkg::DST_CMD_MPSME: begin
                r = idle_ok && !fz && d[`DST_T_NODLL];
            end
            dst_pkg::DST_CMD_DLL: begin
                r = idle_ok && !fz && d[`DST_T_NODLL] &&
                    d[`DST_T_DLL];
            end
            dst_pkg::DST_CMD_SRX: begin
                r = ck && (s == dst_pkg::DST_ST_SR) &&
                    d[`DST_T_BEFORE] && d[`DST_T_CKE];
            end
            dst_pkg::DST_CMD_PDX: begin
                r = ck && (s == dst_pkg::DST_ST_PD) &&
                    d[`DST_T_BEFORE] && d[`DST_T_CKE];
            end
            dst_pkg::DST_CMD_MPSMX: begin
                r = ck && (s == dst_pkg::DST_ST_MPSM) &&
                    d[`DST_T_BEFORE];
            end
            dst_pkg::DST_CMD_RSTX: begin
                r = ck && (s == dst_pkg::DST_ST_RESET) &&
                    d[`DST_T_BEFORE];
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_int_n = rst_s2_reg;

    // One timer per interval class
    for (genvar i = 0; i < N; i++) begin : g_tmr
        dst_timer #(
            .W(W)
        ) u_tmr (
            .mclk   (mclk),
            .rst_n  (rst_int_n),
            .load   (ld[i]),
            .value  (val[i]),
            .done   (done[i]),
            .remain ()
        );
    end

    assign asleep = (st_reg.pstate == dst_pkg::DST_ST_SR) ||
                    (st_reg.pstate == dst_pkg::DST_ST_PD) ||
                    (st_reg.pstate == dst_pkg::DST_ST_MPSM);
    assign cmd_ready = dst_ok(cmd_kind, st_reg.pstate, done,
                              st_reg.first_zq, st_reg.ck_en);
    assign accept = cmd_valid && cmd_ready;
    assign pl_add = par_en ? cyc(PL_NCK) : '0;

    always_comb begin
        st_next         = st_reg;
        st_next.cmd_stb = 1'b0;
        ld              = '0;
        val             = '0;
        // Clock counts as valid from the first cycle after reset
        if (!st_reg.booted) begin
            st_next.booted   = 1'b1;
            ld[`DST_T_BEFORE]  = 1'b1;
            val[`DST_T_BEFORE] = cyc(CKV_C);
        end
        // Clock may stop only asleep and after the post-entry window
        if (ck_stop_req && st_reg.ck_en && asleep &&
            done[`DST_T_AFTER] && !accept) begin
            st_next.ck_en = 1'b0;
        end else if (!ck_stop_req && !st_reg.ck_en) begin
            st_next.ck_en      = 1'b1;
            ld[`DST_T_BEFORE]  = 1'b1;
            val[`DST_T_BEFORE] = cyc(CKV_C);
        end
        if (accept) begin
            st_next.cmd_out = cmd_kind;
            st_next.cmd_stb = 1'b1;
            case (cmd_kind)
                dst_pkg::DST_CMD_ZQCL: begin
                    ld[`DST_T_BUSY] = 1'b1;
                    if (st_reg.first_zq) begin
                        val[`DST_T_BUSY] = cyc(`DST_ZQINIT_NCK);
                    end else begin
                        val[`DST_T_BUSY] = cyc(`DST_ZQOPER_NCK);
                    end
                    st_next.first_zq = 1'b0;
                end
                dst_pkg::DST_CMD_ZQCS: begin
                    ld[`DST_T_BUSY]  = 1'b1;
                    val[`DST_T_BUSY] = cyc(`DST_ZQCS_NCK);
                end
                dst_pkg::DST_CMD_SRE: begin
                    st_next.pstate    = dst_pkg::DST_ST_SR;
                    st_next.cke       = 1'b0;
                    ld[`DST_T_AFTER]  = 1'b1;
                    val[`DST_T_AFTER] = cyc(CKV_C) + pl_add;
                    ld[`DST_T_CKE]    = 1'b1;
                    val[`DST_T_CKE]   = cyc(CKESR_C) + pl_add;
                end
                dst_pkg::DST_CMD_PDE: begin
                    st_next.pstate    = dst_pkg::DST_ST_PD;
                    st_next.cke       = 1'b0;
                    ld[`DST_T_AFTER]  = 1'b1;
                    val[`DST_T_AFTER] = cyc(CKV_C) + pl_add;
                    ld[`DST_T_CKE]    = 1'b1;
                    val[`DST_T_CKE]   = cyc(CKE_C);
                end
                dst_pkg::DST_CMD_MPSME: begin
                    st_next.pstate    = dst_pkg::DST_ST_MPSM;
                    ld[`DST_T_AFTER]  = 1'b1;
                    val[`DST_T_AFTER] = cyc(MPE_C);
                end
                dst_pkg::DST_CMD_SRX: begin
                    st_next.pstate = dst_pkg::DST_ST_IDLE;
                    st_next.cke    = 1'b1;
                    ld[`DST_T_NODLL] = 1'b1;
                    if (sr_abort) begin
                        val[`DST_T_NODLL] = cyc(XS4_C);
                    end else begin
                        val[`DST_T_NODLL] = cyc(XS_C);
                    end
                    ld[`DST_T_FAST]  = 1'b1;
                    val[`DST_T_FAST] = cyc(XS4_C);
                    ld[`DST_T_DLL]   = 1'b1;
                    val[`DST_T_DLL]  = cyc(DLLK_NCK);
                end
                dst_pkg::DST_CMD_MPSMX: begin
                    st_next.pstate    = dst_pkg::DST_ST_IDLE;
                    st_next.cke       = 1'b1;
                    ld[`DST_T_NODLL]  = 1'b1;
                    val[`DST_T_NODLL] = cyc(XS_C);
                    ld[`DST_T_FAST]   = 1'b1;
                    val[`DST_T_FAST]  = cyc(XS_C);
                    ld[`DST_T_DLL]    = 1'b1;
                    val[`DST_T_DLL]   = cyc(XMPDLL_C);
                end
                dst_pkg::DST_CMD_PDX: begin
                    st_next.pstate   = dst_pkg::DST_ST_IDLE;
                    st_next.cke      = 1'b1;
                    ld[`DST_T_BUSY]  = 1'b1;
                    val[`DST_T_BUSY] = cyc(XP_C);
                end
                dst_pkg::DST_CMD_RSTX: begin
                    st_next.pstate   = dst_pkg::DST_ST_IDLE;
                    st_next.cke      = 1'b1;
                    st_next.first_zq = 1'b1;
                    ld[`DST_T_BUSY]  = 1'b1;
                    val[`DST_T_BUSY] = cyc(XPR_C);
                end
                default: begin
                    st_next.pstate = st_reg.pstate;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st_reg.pstate   <= dst_pkg::DST_ST_RESET;
            st_reg.ck_en    <= 1'b1;
            st_reg.cke      <= 1'b0;
            st_reg.booted   <= 1'b0;
            st_reg.first_zq <= 1'b1;
            st_reg.cmd_out  <= dst_pkg::DST_CMD_NOP;
            st_reg.cmd_stb  <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ddr_ck_en   = st_reg.ck_en;
    assign ddr_cke     = st_reg.cke;
    assign ddr_cmd     = st_reg.cmd_out;
    assign ddr_cmd_stb = st_reg.cmd_stb;
    assign rank_state  = st_reg.pstate;

    for (genvar j = 0; j < N; j++) begin : g_run
        assign tmr_running[j] = !done[j];
    end

endmodule

// [bench/dst_guard_properties.sv]
// Timing checker for the rank state-exit guard
`timescale 1ns/1ps
module dst_guard_properties #(
    parameter int RFC_NS   = 550,
    parameter int RFC4_NS  = 160,
    parameter int DLLK_NCK = 768,
    parameter int MOD_NCK  = 24,
    parameter int PL_NCK   = 4
) (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              cmd_valid,
    input wire dst_pkg::dst_cmd_t cmd_kind,
    input wire logic              cmd_ready,
    input wire logic              ck_stop_req,
    input wire logic              par_en,
    input wire logic              sr_abort,
    input wire logic              ddr_ck_en,
    input wire logic              ddr_cke,
    input wire dst_pkg::dst_cmd_t ddr_cmd,
    input wire logic              ddr_cmd_stb,
    input wire dst_pkg::dst_rank_t rank_state,
    input wire logic [6:0]        tmr_running
);
    localparam int XS  = (RFC_NS + 109) / 100;
    localparam int XF  = (RFC4_NS + 109) / 100;
    localparam int XPR = (XS > 5) ? XS : 5;
    logic acc;
    logic ini, ab, mp, em;
    int   gap, sx, ec, lo, on;
    dst_pkg::dst_cmd_t k;
    assign k = cmd_kind;
    assign acc = cmd_valid && cmd_ready && k != dst_pkg::DST_CMD_NOP;
    // Calibration gap countdown, and cycle counts since the last self refresh or power saving exit and the last entry
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 0;
            sx  <= 4095;
            ec  <= 4095;
            lo  <= 0;
            on  <= 0;
            ini <= 1'b0;
            ab  <= 1'b0;
            mp  <= 1'b0;
            em  <= 1'b0;
        end else begin
            lo <= ddr_cke ? 0 : lo + 1;
            on <= ddr_ck_en ? on + 1 : 0;
            if (acc && k == dst_pkg::DST_CMD_RSTX) begin
                gap <= XPR - 1;
                ini <= 1'b1;
            end else if (acc && k == dst_pkg::DST_CMD_ZQCL) begin
                gap <= ini ? 1023 : 511;
                ini <= 1'b0;
            end else if (acc && k == dst_pkg::DST_CMD_ZQCS) begin
                gap <= 127;
            end else if (gap > 0) begin
                gap <= gap - 1;
            end
            if (acc && k inside {dst_pkg::DST_CMD_SRX, dst_pkg::DST_CMD_MPSMX})
            begin
                sx <= 1;
                ab <= sr_abort && k == dst_pkg::DST_CMD_SRX;
                mp <= k == dst_pkg::DST_CMD_MPSMX;
            end else if (sx < 4095) begin
                sx <= sx + 1;
            end
            if (acc && k inside {dst_pkg::DST_CMD_SRE, dst_pkg::DST_CMD_PDE,
                                 dst_pkg::DST_CMD_MPSME}) begin
                ec <= 1;
                em <= k == dst_pkg::DST_CMD_MPSME;
            end else if (ec < 4095) begin
                ec <= ec + 1;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_stb_follows_acc: assert property (cmd_valid && cmd_ready |=>
        ddr_cmd_stb && ddr_cmd == $past(cmd_kind)) else $error("no strobe");
    a_stb_needs_acc: assert property (ddr_cmd_stb |->
        $past(cmd_valid && cmd_ready)) else $error("stray strobe");
    a_zq_gap_kept: assert property (acc |-> gap == 0)
        else $error("calibration gap short");
    a_nodll_wait: assert property (
        acc && k == dst_pkg::DST_CMD_NODLL |->
        sx >= (ab ? XF : XS)) else $error("non-DLL early");
    a_fast_wait: assert property (
        acc && k inside {dst_pkg::DST_CMD_ZQCL,
        dst_pkg::DST_CMD_ZQCS, dst_pkg::DST_CMD_MRS_FAST} |->
        sx >= (mp ? XS : XF)) else $error("fast class early");
    a_dll_wait: assert property (
        acc && k == dst_pkg::DST_CMD_DLL |->
        sx >= (mp ? XS + DLLK_NCK : DLLK_NCK)) else $error("DLL early");
    a_cke_low_width: assert property ($rose(ddr_cke) &&
        $past(rank_state) == dst_pkg::DST_ST_SR |->
        lo >= 4 + (par_en ? PL_NCK : 0)) else $error("cke low short");
    a_clk_after_entry: assert property (
        $fell(ddr_ck_en) |->
        ec > (em ? MOD_NCK + 4 : 5 + (par_en ? PL_NCK : 0)))
        else $error("clock stopped early");
    a_clk_before_exit: assert property (
        acc && k inside {dst_pkg::DST_CMD_SRX, dst_pkg::DST_CMD_PDX,
        dst_pkg::DST_CMD_MPSMX, dst_pkg::DST_CMD_RSTX} |-> on >= 5)
        else $error("exit without clock");
    c_abort_exit: cover property (acc && k == dst_pkg::DST_CMD_SRX && sr_abort);
    c_mpsm_stop: cover property ($fell(ddr_ck_en) && em);
    c_dll_cmd: cover property (acc && k == dst_pkg::DST_CMD_DLL && mp);
endmodule

// [bench/dst_dev_model.sv]
// Rank model: drops its command path after power saving entry
`timescale 1ns/1ps
module dst_dev_model #(
    parameter int MOD_NCK = 24
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ck_en,
    input  wire dst_pkg::dst_cmd_t cmd,
    input  wire logic              cmd_stb,
    output logic                   path_on
);
    int n;
    // Counts only device clocks, so a stopped clock freezes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            n <= 0;
            path_on <= 1'b1;
        end else if (cmd_stb && cmd == dst_pkg::DST_CMD_MPSMX) begin
            n <= 0;
            path_on <= 1'b1;
        end else if (cmd_stb && cmd == dst_pkg::DST_CMD_MPSME) begin
            n <= 1;
        end else if (ck_en && n != 0) begin
            n <= n + 1;
            if (n + 1 >= MOD_NCK + 4) path_on <= 1'b0;
        end
    end
endmodule

// [bench/dst_guard_tb.sv]
// Testbench for the rank state-exit guard
`timescale 1ns/1ps
module dst_guard_tb;
    localparam int DLLK = 8;
    localparam int XS   = (550 + 109) / 100;
    localparam int XF   = (160 + 109) / 100;
    localparam int XPR  = (XS > 5) ? XS : 5;
    logic mclk = 0, rst_n = 0, cmd_valid = 0, ck_stop_req = 0;
    logic par_en = 0, sr_abort = 0;
    logic cmd_ready, ddr_ck_en, ddr_cke, ddr_cmd_stb, path_on;
    logic [6:0] tmr_running;
    dst_pkg::dst_cmd_t cmd_kind = dst_pkg::DST_CMD_NOP, ddr_cmd;
    dst_pkg::dst_rank_t rank_state;
    int num_errors = 0, checks_done = 0, cyc = 0, tacc, t;
    always #50 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    dst_guard #(.DLLK_NCK(DLLK)) dst_guard_i (.mclk(mclk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready),
        .ck_stop_req(ck_stop_req), .par_en(par_en), .sr_abort(sr_abort),
        .ddr_ck_en(ddr_ck_en), .ddr_cke(ddr_cke), .ddr_cmd(ddr_cmd),
        .ddr_cmd_stb(ddr_cmd_stb), .rank_state(rank_state),
        .tmr_running(tmr_running));
    dst_dev_model dst_dev_model_i (.mclk(mclk), .rst_n(rst_n),
        .ck_en(ddr_ck_en), .cmd(ddr_cmd), .cmd_stb(ddr_cmd_stb),
        .path_on(path_on));
    task chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Issue one command; gap is the interval from ref_t, spacing checked as gap+1, 0 for none
    task send(input dst_pkg::dst_cmd_t k, input int ref_t, input int gap);
        int n;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            chk(1'b0, "ready never came");
            test_done;
        end
        tacc = cyc;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(negedge mclk);
        chk(ddr_cmd_stb === 1'b1 && ddr_cmd === k, "no command");
        // A class frees one edge after its interval has run out
        if (gap > 0) chk(tacc - ref_t == gap + 1, "wrong spacing");
    endtask
    // Enter a sleep state, stop and restart the clock, then exit
    task sleep(input dst_pkg::dst_cmd_t ent, input dst_pkg::dst_cmd_t ext,
               input int after);
        int n, te;
        send(ent, 0, 0);
        te = tacc;
        chk(ddr_cke === (ent == dst_pkg::DST_CMD_MPSME), "cke level");
        @(posedge mclk);
        ck_stop_req <= 1'b1;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ddr_ck_en !== 1'b0 && n < 100);
        if (ddr_ck_en !== 1'b0) begin
            chk(1'b0, "clock never stopped");
            test_done;
        end
        // The clock stops on the edge after the window has run out
        chk(cyc - te == after + 2, "clock stop time");
        chk(path_on === (ent != dst_pkg::DST_CMD_MPSME), "path state");
        @(posedge mclk);
        ck_stop_req <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ddr_ck_en !== 1'b1 && n < 100);
        if (ddr_ck_en !== 1'b1) begin
            chk(1'b0, "clock never restarted");
            test_done;
        end
        // Reference is the edge before the restart, as tacc is for accepts
        te = cyc - 1;
        send(ext, te, 5);
    endtask
    task t_boot;
        send(dst_pkg::DST_CMD_RSTX, 0, 0);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_kind <= dst_pkg::DST_CMD_NODLL;
        @(negedge mclk);
        chk(cmd_ready === 1'b0, "command before calibration");
        send(dst_pkg::DST_CMD_ZQCL, tacc, XPR);
        chk(tmr_running[0] === 1'b1, "busy timer idle");
        chk(rank_state === dst_pkg::DST_ST_IDLE, "not idle");
        send(dst_pkg::DST_CMD_ZQCS, tacc, 1024);
        send(dst_pkg::DST_CMD_ZQCL, tacc, 128);
        send(dst_pkg::DST_CMD_ZQCS, tacc, 512);
    endtask
    task t_sref(input logic ab, input logic par);
        @(posedge mclk);
        par_en <= par;
        sr_abort <= ab;
        sleep(dst_pkg::DST_CMD_SRE, dst_pkg::DST_CMD_SRX, 5 + par * 4);
        t = tacc;
        if (!ab) send(dst_pkg::DST_CMD_MRS_FAST, t, XF);
        send(dst_pkg::DST_CMD_NODLL, t, ab ? XF : XS);
        send(dst_pkg::DST_CMD_DLL, t, DLLK);
    endtask
    task t_mpsm;
        @(posedge mclk);
        par_en <= 1'b0;
        sr_abort <= 1'b0;
        sleep(dst_pkg::DST_CMD_MPSME, dst_pkg::DST_CMD_MPSMX, 28);
        t = tacc;
        send(dst_pkg::DST_CMD_NODLL, t, XS);
        send(dst_pkg::DST_CMD_DLL, t, XS + DLLK);
        sleep(dst_pkg::DST_CMD_PDE, dst_pkg::DST_CMD_PDX, 5);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_boot;
        t_sref(1'b0, 1'b0);
        t_sref(1'b1, 1'b1);
        t_mpsm;
        test_done;
    end
endmodule
bind dst_guard dst_guard_properties #(.RFC_NS(RFC_NS), .RFC4_NS(RFC4_NS),
    .DLLK_NCK(DLLK_NCK), .MOD_NCK(MOD_NCK), .PL_NCK(PL_NCK))
    dst_guard_properties_i (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready),
    .ck_stop_req(ck_stop_req), .par_en(par_en), .sr_abort(sr_abort),
    .ddr_ck_en(ddr_ck_en), .ddr_cke(ddr_cke), .ddr_cmd(ddr_cmd),
    .ddr_cmd_stb(ddr_cmd_stb), .rank_state(rank_state),
    .tmr_running(tmr_running));
